// ==== dv/dfps_drive_model.sv ====
// drive core and sensing model facing the protection supervisor
`timescale 1ns/1ps
`default_nettype none
module dfps_drive_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire dfps_pkg::dfps_drive_s drive,
  input wire logic [15:0] setCurrent,
  input wire logic [15:0] setBus,
  input wire logic [1:0] setRamp,
  output var dfps_pkg::dfps_meas_s meas
);
  logic [15:0] freqReg;
  // ramp falls while decelerating unless held, and while limited; frozen when stopped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      freqReg <= 16'h1388;
    end else if (!drive.stopOutput && ((setRamp == 2'h2 && !drive.holdRamp) || drive.limitActive)) begin
      freqReg <= (freqReg > 16'h0001) ? freqReg - 16'h0001 : freqReg;
    end
  end
  // sensed values, rated peak 500 v
  assign meas = '{current: setCurrent, busVolt: setBus, freqHz: freqReg, peakVolt: 16'h01f4,
                  ramp: dfps_pkg::dfps_ramp_e'(setRamp)};
endmodule : dfps_drive_model
`default_nettype wire

// ==== dv/test_dfps_supervisor.sv ====
// self-checking bench for the protection supervisor
`timescale 1ns/1ps
`default_nettype none
module test_dfps_supervisor;
  localparam logic [31:0] M_HOLD = 32'h1;
  localparam logic [31:0] M_LIM = 32'hffff0002;
  localparam logic [31:0] M_STOP = 32'h4;
  localparam logic [31:0] M_REL = 32'h8;
  localparam logic [31:0] M_PRE = 32'h10;
  localparam logic [31:0] M_IRQ = 32'h20;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic classIs380 = 1'b1;
  logic [15:0] setCurrent = 16'h0000;
  logic [15:0] setBus = 16'h0226;
  logic [1:0] setRamp = 2'h0;
  dfps_pkg::dfps_meas_s meas;
  dfps_pkg::dfps_drive_s drive;
  logic faultRelay;
  logic prealarm;
  logic irq;
  logic probe = 1'b0;
  logic chkOn = 1'b0;
  logic [31:0] rdData;
  logic [31:0] obs;
  logic [15:0] rate;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  string nameQ[$];
  logic [31:0] maskQ[$];
  logic [31:0] expQ[$];
  wire [31:0] portObs = {drive.fallRate, 10'h0, irq, prealarm, faultRelay, drive.stopOutput,
                         drive.limitActive, drive.holdRamp};
  // clock at 50 mhz
  always #10 clock = ~clock;
  dfps_supervisor u_dfps_supervisor (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .meas(meas),
    .classIs380(classIs380), .drive(drive), .faultRelay(faultRelay), .prealarm(prealarm), .irq(irq));
  dfps_drive_model u_dfps_drive_model (.clock(clock), .rst_n(rst_n), .drive(drive),
    .setCurrent(setCurrent), .setBus(setBus), .setRamp(setRamp), .meas(meas));
  // watcher: oldest note against the result as it shows
  always @(negedge clock) begin
    if ((chkOn && read && !waitrequest) || probe) begin
      obs = probe ? portObs : readdata;
      checked++;
      if ((obs & maskQ[0]) !== expQ[0]) begin
        num_errors++;
        $display("unexpected %s: expected %h, seen %h", nameQ[0], expQ[0], obs & maskQ[0]);
      end
      void'(nameQ.pop_front());
      void'(maskQ.pop_front());
      void'(expQ.pop_front());
    end
  end
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      test_done();
    end
  end
  // one bus cycle, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic [5:0] a, input logic rd, input logic [31:0] d, input logic chk);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= d;
    chkOn <= chk;
    @(posedge clock);
    while (waitrequest) begin
      @(posedge clock);
    end
    rdData = readdata;
    read <= 1'b0;
    write <= 1'b0;
    chkOn <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(a, 1'b0, d, 1'b0);
  endtask : wr
  // poll a register, then note and make one checked read
  task automatic er(input string n, input logic [5:0] a, input logic [31:0] m, input logic [31:0] v);
    int i;
    for (i = 0; i < 40; i++) begin
      bus(a, 1'b1, 32'h0, 1'b0);
      if ((rdData & m) === v) break;
    end
    nameQ.push_back(n);
    maskQ.push_back(m);
    expQ.push_back(v);
    bus(a, 1'b1, 32'h0, 1'b1);
  endtask : er
  // let outputs settle, wait a bounded time for the value, then note and probe
  task automatic ep(input string n, input logic [31:0] m, input logic [31:0] v);
    int i;
    repeat (3) @(posedge clock);
    for (i = 0; i < 40 && (portObs & m) !== v; i++) @(posedge clock);
    nameQ.push_back(n);
    maskQ.push_back(m);
    expQ.push_back(v);
    probe <= 1'b1;
    @(posedge clock);
    probe <= 1'b0;
  endtask : ep
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    void'($urandom(58));
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    er("ctrl", 6'h00, 32'hffffffff, 32'h21);
    er("level", 6'h04, 32'hffffffff, 32'h04b003e8);
    er("limit", 6'h08, 32'hffff0000, 32'h05dc0000);
    er("uv point", 6'h18, 32'hffff0000, 32'h01900000);
    er("unmapped", 6'h20, 32'hffffffff, 32'h0);
    $display("test registers done");
    wr(6'h00, 32'h4);
    setRamp <= 2'h2;
    setBus <= 16'h028a;
    ep("hold over point", M_HOLD, M_HOLD);
    setBus <= 16'h0226;
    ep("hold released", M_HOLD, 32'h0);
    wr(6'h04, 32'h057803e8);
    setBus <= 16'h028a;
    ep("hold raised point", M_HOLD, 32'h0);
    wr(6'h04, 32'h04b003e8);
    ep("hold again", M_HOLD, M_HOLD);
    wr(6'h00, 32'h0);
    ep("hold disabled", M_HOLD, 32'h0);
    setBus <= 16'h0226;
    $display("test stall done");
    rate = 16'($urandom % 10000);
    wr(6'h0c, {16'h0000, rate});
    for (int m = 0; m < 3; m++) begin
      for (int r = 0; r < 3; r++) begin
        wr(6'h00, {26'h0, 2'(m), 4'h0});
        setRamp <= 2'(r);
        setCurrent <= 16'h05dd + 16'($urandom % 400);
        ep("limit", M_LIM, {rate, 14'h0, m == 2 || (m == 1 && r != 0), 1'b0});
      end
    end
    setCurrent <= 16'($urandom % 1500);
    ep("limit below", M_LIM, {rate, 16'h0});
    wr(6'h04, 32'h04b001f4);
    setCurrent <= 16'h0320;
    ep("limit scaled", M_LIM, {rate, 16'h2});
    wr(6'h04, 32'h04b003e8);
    $display("test limit done");
    wr(6'h00, 32'h0);
    wr(6'h08, 32'h05dc03e8);
    setRamp <= 2'h1;
    setCurrent <= 16'h044c;
    ep("prealarm accel", M_PRE, 32'h0);
    setRamp <= 2'h0;
    ep("prealarm const", M_PRE, M_PRE);
    setCurrent <= 16'h0384;
    ep("prealarm below", M_PRE, 32'h0);
    wr(6'h00, 32'h8);
    setRamp <= 2'h1;
    setCurrent <= 16'h044c;
    ep("prealarm always", M_PRE, M_PRE);
    setCurrent <= 16'h0000;
    er("status prealarm", 6'h10, 32'h4, 32'h4);
    wr(6'h14, 32'h4);
    ep("irq on", M_IRQ, M_IRQ);
    wr(6'h10, 32'h4);
    ep("irq cleared", M_IRQ, 32'h0);
    $display("test prealarm done");
    setRamp <= 2'h0;
    wr(6'h00, 32'h0);
    setBus <= 16'h012c;
    ep("uv ignored", M_REL, 32'h0);
    setRamp <= 2'h3;
    wr(6'h00, 32'h100);
    ep("uv stopped", M_REL, 32'h0);
    setBus <= 16'h0226;
    setRamp <= 2'h0;
    wr(6'h00, 32'h1200);
    setBus <= 16'h012c;
    er("state wait", 6'h18, 32'h3, 32'h1);
    ep("retry quiet", M_REL | M_STOP, M_STOP);
    wr(6'h00, 32'h1240);
    ep("retry relay", M_REL, M_REL);
    setBus <= 16'h0226;
    er("retry done", 6'h18, 32'h1f, 32'h4);
    er("status retry", 6'h10, 32'h8, 32'h8);
    ep("resumed", M_STOP, 32'h0);
    setBus <= 16'h012c;
    er("state lock", 6'h18, 32'h3, 32'h2);
    ep("lock relay", M_REL | M_STOP, M_REL | M_STOP);
    setBus <= 16'h0226;
    wr(6'h1c, 32'h1);
    er("manual clear", 6'h18, 32'h1f, 32'h0);
    wr(6'h00, 32'h200);
    setRamp <= 2'h3;
    setBus <= 16'h012c;
    ep("uv all stopped", M_REL, M_REL);
    er("status uv", 6'h10, 32'h2, 32'h2);
    setBus <= 16'h0226;
    wr(6'h1c, 32'h1);
    er("no overload trip", 6'h10, 32'h1, 32'h0);
    $display("test fault done");
    test_done();
  end
endmodule : test_dfps_supervisor
`default_nettype wire

// ==== logic/dfps_supervisor.sv ====
// protection supervisor: overload, stall, current limit, under-voltage, auto reset
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module dfps_supervisor (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire dfps_pkg::dfps_meas_s meas,
  input wire logic classIs380,
  output var dfps_pkg::dfps_drive_s drive,
  output logic faultRelay,
  output logic prealarm,
  output logic irq
);
  //--------------------------------------------------
  // register file
  //--------------------------------------------------
  logic [31:0] ctrl_reg, level_reg, limit_reg, reset_reg, uv_reg;
  logic [dfps_pkg::ST_W-1:0] status_reg, mask_reg;
  logic ack_reg;
  logic [2:0] uvInit_reg;
  logic class_s1_reg, class_s2_reg;
  // field pulls
  wire [1:0] overloadProtectMode = ctrl_reg[1:0];
  wire ovStallEnable = ctrl_reg[2];
  wire prealarmMonitorMode = ctrl_reg[3];
  wire [1:0] currentLimitActionMode = ctrl_reg[5:4];
  wire resetRelayAction = ctrl_reg[6];
  wire [1:0] undervoltActionSelect = ctrl_reg[9:8];
  wire [15:0] overloadProtectFactor = level_reg[15:0];
  wire [15:0] ovStallPoint = level_reg[31:16];
  wire [15:0] prealarmThreshold = limit_reg[15:0];
  wire [15:0] currentLimitThreshold = limit_reg[31:16];
  wire [15:0] limitFreqFallRate = reset_reg[15:0];
  wire [7:0] prealarmDelay = reset_reg[23:16];
  wire [7:0] autoResetInterval = reset_reg[31:24];
  wire [2:0] autoResetCount = ctrl_reg[14:12];
  wire [15:0] undervoltPoint = uv_reg[15:0];
  // bus decode
  // a write lands only at the edge where waitrequest is low
  wire wrStrobe = write & ack_reg;
  wire rdStrobe = read & ~ack_reg;
  wire wrCtrl = wrStrobe && address == dfps_pkg::OFS_CTRL;
  wire wrLevel = wrStrobe && address == dfps_pkg::OFS_LEVEL;
  wire wrLimit = wrStrobe && address == dfps_pkg::OFS_LIMIT;
  wire wrReset = wrStrobe && address == dfps_pkg::OFS_RESET;
  wire wrStatus = wrStrobe && address == dfps_pkg::OFS_STATUS;
  wire wrMask = wrStrobe && address == dfps_pkg::OFS_MASK;
  wire wrCmd = wrStrobe && address == dfps_pkg::OFS_CMD;
  wire manualClear = wrCmd & writedata[0];
  wire wrUv = wrCmd & writedata[1];
  assign waitrequest = (read | write) & ~ack_reg;

  //--------------------------------------------------
  // time base: 100 ms ticks
  //--------------------------------------------------
  logic [22:0] tickCnt_reg;
  wire tick = tickCnt_reg == 23'(dfps_pkg::TICK_CYCLES - 1);
  // free-running divider, one tick pulse per period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) tickCnt_reg <= '0;
    else tickCnt_reg <= tick ? '0 : tickCnt_reg + 23'h1;
  end

  //--------------------------------------------------
  // measurements and scaled levels
  //--------------------------------------------------
  wire [15:0] cur = meas.current;
  wire running = meas.ramp != dfps_pkg::RAMP_STOP;
  // motor level = rated scaled by factor; low speed derates standard motor
  wire [31:0] factorProd = 32'(overloadProtectFactor) * 32'(dfps_pkg::PCT_FULL);
  wire [15:0] motorLevel = 16'(factorProd / 32'(dfps_pkg::PCT_FULL)); // R3
  wire [15:0] derated = (overloadProtectMode == dfps_pkg::OLM_STD && meas.freqHz < dfps_pkg::LOW_SPEED_HZ)
                        ? 16'((32'(motorLevel) * 32'(dfps_pkg::DERATE_MUL)) >> dfps_pkg::DERATE_SHIFT)
                        : motorLevel; // R1
  wire [31:0] limitProd = 32'(currentLimitThreshold) * 32'(overloadProtectFactor);
  wire [15:0] limitLevel = 16'(limitProd / 32'(dfps_pkg::PCT_FULL)); // R3 R9
  wire [31:0] stallProd = 32'(meas.peakVolt) * 32'(ovStallPoint);
  wire [15:0] stallVolt = 16'(stallProd / 32'(dfps_pkg::PCT_FULL)); // R6

  //--------------------------------------------------
  // overload heat accumulator
  //--------------------------------------------------
  logic [23:0] heat_reg;
  wire heatOn = overloadProtectMode != dfps_pkg::OLM_OFF; // R1
  wire over = cur > derated;
  wire [23:0] excess = 24'(cur - derated);
  wire heatFull = heat_reg >= dfps_pkg::HEAT_FULL; // R2
  // heat grows by the excess each tick and cools by one when under level
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) heat_reg <= '0;
    else if (!heatOn) heat_reg <= '0;
    else if (tick && over && !heatFull) heat_reg <= heat_reg + excess;
    else if (tick && !over && heat_reg != '0) heat_reg <= heat_reg - 24'h1;
  end

  //--------------------------------------------------
  // overload pre-alarm with restartable delay
  //--------------------------------------------------
  logic [7:0] preCnt_reg;
  logic prealarm_reg;
  wire preWatch = prealarmMonitorMode || meas.ramp == dfps_pkg::RAMP_CONST; // R7
  wire preOver = preWatch && cur > prealarmThreshold; // R8
  // delay count restarts whenever current drops under the threshold
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_reg <= '0;
      prealarm_reg <= 1'b0;
    end else if (!preOver) begin
      preCnt_reg <= '0; // R17
      prealarm_reg <= 1'b0;
    end else begin
      if (tick && preCnt_reg < prealarmDelay) preCnt_reg <= preCnt_reg + 8'h1;
      prealarm_reg <= preCnt_reg >= prealarmDelay; // R17
    end
  end
  assign prealarm = prealarm_reg;

  //--------------------------------------------------
  // stall hold and current limit
  //--------------------------------------------------
  wire limitEnabled = currentLimitActionMode == dfps_pkg::CLM_ALL
                      || (currentLimitActionMode == dfps_pkg::CLM_RAMP
                          && (meas.ramp == dfps_pkg::RAMP_ACC || meas.ramp == dfps_pkg::RAMP_DEC)); // R11
  wire stallNext = ovStallEnable && meas.ramp == dfps_pkg::RAMP_DEC && meas.busVolt > stallVolt; // R4 R5
  wire limitNext = limitEnabled && running && cur > limitLevel; // R9

  //--------------------------------------------------
  // fault sequencing and auto reset
  //--------------------------------------------------
  dfps_pkg::dfps_fault_e fs_reg, fs_next;
  logic [7:0] waitCnt_reg;
  logic [2:0] retries_reg;
  logic relay_reg;
  wire uvLow = meas.busVolt < undervoltPoint; // R16
  wire uvReport = undervoltActionSelect == dfps_pkg::UVA_ALL
                  || (undervoltActionSelect == dfps_pkg::UVA_RUN && running); // R15
  wire uvFault = uvLow && uvReport;
  wire faultEvent = (heatOn && heatFull) || uvFault;
  wire retryLeft = retries_reg < autoResetCount; // R12
  wire waitDone = waitCnt_reg >= autoResetInterval;
  // fault state: run, wait for auto reset, or locked until manual clear
  always_comb begin
    fs_next = fs_reg;
    case (fs_reg)
      dfps_pkg::FS_RUN: if (faultEvent) fs_next = retryLeft ? dfps_pkg::FS_WAIT : dfps_pkg::FS_LOCK; // R12
      dfps_pkg::FS_WAIT: if (waitDone && !faultEvent) fs_next = dfps_pkg::FS_RUN; // R13
      dfps_pkg::FS_LOCK: if (manualClear && !faultEvent) fs_next = dfps_pkg::FS_RUN;
      default: fs_next = dfps_pkg::FS_RUN;
    endcase
  end
  // state, reset interval counter and retries used
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fs_reg <= dfps_pkg::FS_RUN;
      waitCnt_reg <= '0;
      retries_reg <= '0;
    end else begin
      fs_reg <= fs_next;
      if (fs_reg != dfps_pkg::FS_WAIT) waitCnt_reg <= '0;
      else if (tick && !waitDone) waitCnt_reg <= waitCnt_reg + 8'h1; // R13
      if (manualClear) retries_reg <= '0;
      else if (fs_reg == dfps_pkg::FS_RUN && fs_next == dfps_pkg::FS_WAIT) retries_reg <= retries_reg + 3'h1;
    end
  end
  // relay: locked faults always act; retry wait acts only when chosen
  wire relayNext = fs_next == dfps_pkg::FS_LOCK
                   || (fs_next == dfps_pkg::FS_WAIT && resetRelayAction); // R14
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) relay_reg <= 1'b0;
    else relay_reg <= relayNext;
  end
  assign faultRelay = relay_reg;

  // drive outputs from flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) drive <= '0;
    else begin
      drive.holdRamp <= stallNext; // R5
      drive.limitActive <= limitNext; // R10
      drive.fallRate <= limitFreqFallRate; // R10
      drive.stopOutput <= fs_next != dfps_pkg::FS_RUN; // R13
    end
  end

  //--------------------------------------------------
  // interrupt status, set wins over clear
  //--------------------------------------------------
  wire [dfps_pkg::ST_W-1:0] events;
  assign events[dfps_pkg::ST_OVERLOAD] = heatOn && heatFull && fs_reg == dfps_pkg::FS_RUN;
  assign events[dfps_pkg::ST_UNDERVOLT] = uvFault && fs_reg == dfps_pkg::FS_RUN; // R15
  assign events[dfps_pkg::ST_PREALARM] = preOver && preCnt_reg >= prealarmDelay && !prealarm_reg;
  assign events[dfps_pkg::ST_RETRY] = fs_reg == dfps_pkg::FS_WAIT && fs_next == dfps_pkg::FS_RUN;
  wire [dfps_pkg::ST_W-1:0] clearBits = wrStatus ? writedata[dfps_pkg::ST_W-1:0] : '0;
  // sticky bits; an event in the clearing cycle stays set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) status_reg <= '0;
    else status_reg <= (status_reg & ~clearBits) | events;
  end
  assign irq = |(status_reg & mask_reg);

  //--------------------------------------------------
  // register writes and read mux
  //--------------------------------------------------
  // settings, mask and the one-cycle wait state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= dfps_pkg::CTRL_RST;
      level_reg <= {dfps_pkg::PCT_STALL_RST, dfps_pkg::PCT_FACTOR_RST};
      limit_reg <= {dfps_pkg::PCT_LIMIT_RST, dfps_pkg::PCT_PRE_RST};
      reset_reg <= {dfps_pkg::INTERVAL_RST, dfps_pkg::PRE_DELAY_RST, dfps_pkg::RATE_RST};
      mask_reg <= '0;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
      if (wrCtrl) ctrl_reg <= writedata;
      if (wrLevel) level_reg <= writedata;
      if (wrLimit) limit_reg <= writedata;
      if (wrReset) reset_reg <= writedata;
      if (wrMask) mask_reg <= writedata[dfps_pkg::ST_W-1:0];
    end
  end
  // under-voltage point: class default loaded once the strap has passed both sync stages
  wire uvLoad = uvInit_reg[1] & ~uvInit_reg[2];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      class_s1_reg <= 1'b0;
      class_s2_reg <= 1'b0;
      uvInit_reg <= '0;
      uv_reg <= '0;
    end else begin
      class_s1_reg <= classIs380;
      class_s2_reg <= class_s1_reg;
      uvInit_reg <= {uvInit_reg[1:0], 1'b1};
      if (wrUv) uv_reg <= {16'h0, writedata[31:16]};
      else if (uvLoad) uv_reg <= 32'(class_s2_reg ? dfps_pkg::UV_380_RST : dfps_pkg::UV_220_RST); // R16
    end
  end
  // read selection, registered at the first request edge
  logic [31:0] rdMux;
  always_comb begin
    case (address)
      dfps_pkg::OFS_CTRL: rdMux = ctrl_reg;
      dfps_pkg::OFS_LEVEL: rdMux = level_reg;
      dfps_pkg::OFS_LIMIT: rdMux = limit_reg;
      dfps_pkg::OFS_RESET: rdMux = reset_reg;
      dfps_pkg::OFS_STATUS: rdMux = 32'(status_reg);
      dfps_pkg::OFS_MASK: rdMux = 32'(mask_reg);
      dfps_pkg::OFS_STATE: rdMux = {uv_reg[15:0], 8'(heat_reg[23:16]), 3'h0, retries_reg, 2'(fs_reg)};
      default: rdMux = '0;
    endcase
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) readdata <= '0;
    else if (rdStrobe) readdata <= rdMux;
  end

  //--------------------------------------------------
  // assertions
  //--------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_stall_hold: assert property (ovStallEnable && meas.ramp == dfps_pkg::RAMP_DEC && meas.busVolt > stallVolt // R5
    |=> drive.holdRamp) else $error("stall hold missing");
  a_stall_off: assert property (!ovStallEnable |=> !drive.holdRamp) else $error("stall while disabled"); // R4
  a_limit_mode0: assert property (currentLimitActionMode == dfps_pkg::CLM_OFF |=> !drive.limitActive) // R11
    else $error("limit while disabled");
  a_limit_const: assert property (currentLimitActionMode == dfps_pkg::CLM_RAMP // R11
    && meas.ramp == dfps_pkg::RAMP_CONST |=> !drive.limitActive) else $error("limit at constant speed in mode 1");
  a_pre_restart: assert property (!preOver |=> preCnt_reg == '0 && !prealarm) // R17
    else $error("pre-alarm not restarted");
  a_pre_const: assert property (!prealarmMonitorMode && meas.ramp != dfps_pkg::RAMP_CONST |=> !prealarm) // R7
    else $error("pre-alarm outside constant speed");
  a_pre_delay: assert property ($rose(prealarm) |-> $past(preOver) // R17
    && $past(preCnt_reg) >= $past(prealarmDelay)) else $error("pre-alarm before its delay");
  a_zero_retry: assert property (autoResetCount == '0 && fs_reg == dfps_pkg::FS_RUN && faultEvent // R12
    |=> fs_reg == dfps_pkg::FS_LOCK) else $error("auto reset while disabled");
  a_fault_stop: assert property (fs_reg != dfps_pkg::FS_RUN |-> drive.stopOutput) // R13
    else $error("output not stopped");
  a_relay_quiet: assert property (!resetRelayAction && fs_next == dfps_pkg::FS_WAIT |=> !faultRelay) // R14
    else $error("relay acted in reset period");
  a_uv_none: assert property (undervoltActionSelect == dfps_pkg::UVA_NONE && !heatFull // R15
    && fs_reg == dfps_pkg::FS_RUN |=> fs_reg == dfps_pkg::FS_RUN) else $error("under-voltage fault while off");
  a_uv_relay: assert property (uvFault && fs_reg == dfps_pkg::FS_RUN && !retryLeft |=> faultRelay) // R15
    else $error("under-voltage lock without relay");
  a_heat_trip: assert property (heatOn && heatFull && fs_reg == dfps_pkg::FS_RUN |=> fs_reg != dfps_pkg::FS_RUN) // R2
    else $error("overload did not trip");
  a_rate_copy: assert property (1'b1 |=> drive.fallRate == $past(limitFreqFallRate)) // R10
    else $error("fall rate not passed on");
  // the slave answers after exactly one wait state
  a_bus_wait: assert property (waitrequest |=> !waitrequest) else $error("more than one wait state");
  c_retry: cover property (fs_reg == dfps_pkg::FS_WAIT ##1 fs_reg == dfps_pkg::FS_RUN);
  c_lock: cover property (fs_reg == dfps_pkg::FS_LOCK);
  c_stall: cover property (drive.holdRamp);
  c_prealarm: cover property (prealarm);
  c_limit: cover property (drive.limitActive);
endmodule : dfps_supervisor
`default_nettype wire

// ==== pkg/dfps_pkg.sv ====
// package of constants and types for the drive fault protection supervisor
// Summary of operation
// R1 - overload protect mode: 0 off, 1 standard motor with low-speed derating, 2 inverter-duty motor
// R2 - overload fault trips when accumulated overload reaches full scale
// R3 - overload level and current limit scale with the protection factor
// R4 - over-voltage stall enable: 0 off, 1 on
// R5 - while decelerating with stall on, freeze frequency while bus above stall point
// R6 - stall point is a percentage of rated peak voltage
// R7 - pre-alarm monitored only at constant speed (0) or always (1)
// R8 - pre-alarm threshold is percent of rated current, with a configurable delay
// R9 - current limit threshold is percent of rated current, held in real time
// R10 - in current limiting, frequency falls at a configurable rate
// R11 - current limit mode: 0 off, 1 ramps only, 2 ramps and constant speed
// R12 - auto reset count limits retries; zero means manual reset only
// R13 - fault stops output; after interval, clears and resumes while retries remain
// R14 - relay operates during auto reset period only when relay action is 1
// R15 - under-voltage: 0 no relay or code, 1 only running, 2 always
// R16 - bus compared to under-voltage point; defaults 400 V and 250 V DC
// R17 - pre-alarm only after current stays above threshold for full delay
package dfps_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
  // register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_LEVEL = 6'h04;
  localparam logic [5:0] OFS_LIMIT = 6'h08;
  localparam logic [5:0] OFS_RESET = 6'h0c;
  localparam logic [5:0] OFS_STATUS = 6'h10;
  localparam logic [5:0] OFS_MASK = 6'h14;
  localparam logic [5:0] OFS_STATE = 6'h18;
  localparam logic [5:0] OFS_CMD = 6'h1c;
  // scaling: percent values in tenths, full scale 1000
  localparam logic [15:0] PCT_FULL = 16'h03e8;
  localparam logic [15:0] PCT_FACTOR_RST = 16'h03e8;
  localparam logic [15:0] PCT_STALL_RST = 16'h04b0;
  localparam logic [15:0] PCT_PRE_RST = 16'h05dc;
  localparam logic [15:0] PCT_LIMIT_RST = 16'h05dc;
  localparam logic [15:0] UV_380_RST = 16'h0190;
  localparam logic [15:0] UV_220_RST = 16'h00fa;
  localparam logic [15:0] RATE_RST = 16'h01f4;
  localparam logic [7:0] PRE_DELAY_RST = 8'h32;
  localparam logic [7:0] INTERVAL_RST = 8'h14;
  localparam logic [2:0] COUNT_RST = 3'h0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0021; // standard motor mode, limit in ramps and constant speed
  // standard motor keeps three quarters of its overload level at low speed
  localparam int DERATE_MUL = 3;
  localparam int DERATE_SHIFT = 2;
  localparam logic [23:0] HEAT_FULL = 24'h989680;
  localparam logic [15:0] LOW_SPEED_HZ = 16'h0fa0;
  localparam logic [1:0] OLM_OFF = 2'h0;
  localparam logic [1:0] OLM_STD = 2'h1;
  localparam logic [1:0] OLM_INV = 2'h2;
  localparam logic [1:0] CLM_OFF = 2'h0;
  localparam logic [1:0] CLM_RAMP = 2'h1;
  localparam logic [1:0] CLM_ALL = 2'h2;
  localparam logic [1:0] UVA_NONE = 2'h0;
  localparam logic [1:0] UVA_RUN = 2'h1;
  localparam logic [1:0] UVA_ALL = 2'h2;
  // status bit positions
  localparam int ST_OVERLOAD = 0;
  localparam int ST_UNDERVOLT = 1;
  localparam int ST_PREALARM = 2;
  localparam int ST_RETRY = 3;
  localparam int ST_W = 4;
  typedef enum logic [1:0] {RAMP_CONST, RAMP_ACC, RAMP_DEC, RAMP_STOP} dfps_ramp_e;
  typedef enum {FS_RUN, FS_WAIT, FS_LOCK} dfps_fault_e;
  typedef struct packed {
    logic [15:0] current;   // output current, percent of rated in tenths
    logic [15:0] busVolt;   // dc bus voltage in volts
    logic [15:0] freqHz;    // output frequency in centihertz
    logic [15:0] peakVolt;  // rated peak voltage in volts
    dfps_ramp_e ramp;
  } dfps_meas_s;
  typedef struct packed {
    logic holdRamp;
    logic limitActive;
    logic [15:0] fallRate;
    logic stopOutput;
  } dfps_drive_s;
endpackage : dfps_pkg
